// ==== shared/scm_regs.vh ====
// Constants for the serial configuration memory readout block.
// Assumes a single core clock; no software-visible registers.
`ifndef SCM_REGS_VH
`define SCM_REGS_VH

// Core clock rate in MHz
`define SCM_CLK_MHZ 40
// Power-on reset interval in ns, and the least number of core cycles covering it
`define SCM_POR_NS 1000
`define SCM_POR_CYCLES ((`SCM_POR_NS * `SCM_CLK_MHZ + 999) / 1000)
`define SCM_POR_CNT_W 8

// Stream size in bits, storage word width and write FIFO depth
`define SCM_STREAM_BITS 1048576
`define SCM_WORD_W 8
`define SCM_FIFO_DEPTH 32

// Bit positions in the synchronised input vector
`define SCM_IN_LINK 4
`define SCM_IN_CE 3
`define SCM_IN_OE 2
`define SCM_IN_PROG 1
`define SCM_IN_POL 0
`define SCM_IN_W 5
// Idle pin levels: chip-enable and program-select high, the rest low
`define SCM_IN_IDLE 5'h0a

`endif

// ==== logic/scm_fifo.v ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`include "scm_regs.vh"
module scm_fifo #(
  parameter WIDTH = `SCM_WORD_W,
  parameter DEPTH = `SCM_FIFO_DEPTH
) (
  input wire clk,
  input wire rst,
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  output reg inReady,
  output wire outValid,
  output wire [WIDTH-1:0] outData,
  input wire outReady
);
  localparam AW = $clog2(DEPTH);
  localparam [31:0] DEPTH_I = DEPTH;
  localparam [AW:0] FULL_CNT = DEPTH_I[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  reg [AW:0] count_nxt;
  wire push;
  wire pop;

  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_r];

  always @* begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      inReady <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_nxt;
      // Registered so the port comes straight from a flop
      inReady <= (count_nxt != FULL_CNT);
    end
  end
endmodule // scm_fifo

// ==== logic/scm_readout.v ====
// Serial readout and cascade control of a one-bit configuration stream memory.
// Assumes the link clock and control pins are asynchronous to core_clk and
// are sampled well above their rate; the two-wire programming engine sits
// outside and hands over bytes on the same clock as this block.
`timescale 1ns/1ps
`include "scm_regs.vh"

// Functional notes
// - Ready indicator released to high impedance once power-on reset interval ends.
// - Link clock edge after final stored bit drives chain-enable output low.
// - After the final bit the serial data driver turns off.
// - Low chip-enable on a downstream part enables its own data output.
// - Active counter-clear level after configuration clears the counters.
// - A stored polarity setting selects clear versus enable level of that input; here the setting comes from the clearPolarityInv pin.
// - Low program-mode select enters programming; high keeps readout operation.
// - In programming mode memory is written from the external two-wire master.
// - High chip-enable puts the device in low-power standby.
// - In standby the data output stays off whatever the enable input does.
// - Clear level clears both address and bit counters.
// - Counting and data drive only with chip-enable low and enable high.
// - Chain-enable stays low, then follows chip-enable, then high until reread.
// - In programming mode chip-enable gates neither readout nor standby, but chain-enable still follows it.
module scm_readout #(
  parameter STREAM_BITS = `SCM_STREAM_BITS,
  parameter WORD_W = `SCM_WORD_W,
  parameter FIFO_DEPTH = `SCM_FIFO_DEPTH
) (
  input wire core_clk,
  input wire rst,
  input wire linkClk,
  input wire chipEnableN,
  input wire resetOe,
  input wire program_mode_select_n,
  input wire clearPolarityInv,
  input wire progValid,
  input wire [WORD_W-1:0] progData,
  output wire progReady,
  output reg serialData,
  output reg serialDataOe,
  output reg chain_enable_out_n,
  output reg readyOut,
  output reg readyOe,
  output reg standby
);
  localparam WORDS = STREAM_BITS / WORD_W;
  localparam AW = $clog2(WORDS);
  localparam BW = $clog2(WORD_W);
  // Full-width helpers, cut on purpose to the counter widths below
  localparam [31:0] WORDS_M1 = WORDS - 1;
  localparam [31:0] BITS_M1 = WORD_W - 1;
  localparam [31:0] POR_M1 = `SCM_POR_CYCLES - 1;
  localparam [AW-1:0] LAST_ADDR = WORDS_M1[AW-1:0];
  localparam [BW-1:0] LAST_BIT = BITS_M1[BW-1:0];
  localparam [`SCM_POR_CNT_W-1:0] POR_LAST = POR_M1[`SCM_POR_CNT_W-1:0];
  // Synchroniser reset equals the idle pin levels, so no false select follows reset
  localparam [`SCM_IN_W-1:0] SYNC_IDLE = `SCM_IN_IDLE;

  localparam [1:0] CHN_HIGH = 2'b00;
  localparam [1:0] CHN_LOW = 2'b01;
  localparam [1:0] CHN_FOLLOW = 2'b10;

  // Storage array for the configuration stream
  reg [WORD_W-1:0] mem [0:WORDS-1];

  reg [`SCM_IN_W-1:0] meta_r;
  reg [`SCM_IN_W-1:0] sync_r;
  reg linkPrev_r;
  reg [`SCM_POR_CNT_W-1:0] porCnt_r;
  reg [`SCM_POR_CNT_W-1:0] porCnt_nxt;
  reg porDone_r;
  reg porDone_nxt;
  reg [AW-1:0] addr_r;
  reg [AW-1:0] addr_nxt;
  reg [BW-1:0] bit_r;
  reg [BW-1:0] bit_nxt;
  reg done_r;
  reg done_nxt;
  reg [AW-1:0] wrAddr_r;
  reg [1:0] chnState_r;
  reg [1:0] chnState_nxt;
  reg chn_nxt;

  wire [`SCM_IN_W-1:0] rawIn;
  wire linkRise;
  wire progMode;
  wire ceLow;
  wire oeActive;
  wire clearCnt;
  wire readEn;
  wire lastBit;
  wire drive;
  wire fifoValid;
  wire [WORD_W-1:0] fifoData;
  wire [WORD_W-1:0] rdWord;
  wire wrTake;

  // Pins gathered into one vector for the synchronisers
  assign rawIn[`SCM_IN_LINK] = linkClk;
  assign rawIn[`SCM_IN_CE] = chipEnableN;
  assign rawIn[`SCM_IN_OE] = resetOe;
  assign rawIn[`SCM_IN_PROG] = program_mode_select_n;
  assign rawIn[`SCM_IN_POL] = clearPolarityInv;

  // Two-stage synchronisers; only sync_r is read by logic
  genvar g;
  generate
    for (g = 0; g < `SCM_IN_W; g = g + 1) begin : gSync
      always @(posedge core_clk) begin
        if (rst) begin
          meta_r[g] <= SYNC_IDLE[g];
          sync_r[g] <= SYNC_IDLE[g];
        end else begin
          meta_r[g] <= rawIn[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  // Previous link level; reset low like the idle clock, so no false edge
  always @(posedge core_clk) begin
    if (rst) begin
      linkPrev_r <= 1'b0;
    end else begin
      linkPrev_r <= sync_r[`SCM_IN_LINK];
    end
  end

  assign linkRise = sync_r[`SCM_IN_LINK] & ~linkPrev_r;
  assign progMode = ~sync_r[`SCM_IN_PROG];
  assign ceLow = ~sync_r[`SCM_IN_CE];
  // Polarity setting flips which level enables and which clears
  assign oeActive = sync_r[`SCM_IN_OE] ^ sync_r[`SCM_IN_POL];
  assign clearCnt = ~progMode & ~oeActive;
  // Chip-enable gates readout only outside programming mode
  assign readEn = porDone_r & ~progMode & ceLow & oeActive;
  assign lastBit = (addr_r == LAST_ADDR) && (bit_r == LAST_BIT);
  assign drive = readEn & ~done_r;
  assign rdWord = mem[addr_r];

  // One decode for counters and chain sequencer, so both see the same final edge
  function take_edge;
    input en;
    input rise;
    input finished;
    begin
      take_edge = en & rise & ~finished;
    end
  endfunction

  // Power-on reset interval before the part answers; readout stays off until it ends
  always @* begin
    porCnt_nxt = porCnt_r;
    porDone_nxt = porDone_r;
    if (!porDone_r) begin
      if (porCnt_r == POR_LAST) begin
        porDone_nxt = 1'b1;
      end else begin
        porCnt_nxt = porCnt_r + 1'b1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      porCnt_r <= {`SCM_POR_CNT_W{1'b0}};
      porDone_r <= 1'b0;
      readyOut <= 1'b0;
      readyOe <= 1'b1;
    end else begin
      porCnt_r <= porCnt_nxt;
      porDone_r <= porDone_nxt;
      // Open-drain pin: only ever pulls low, released when the interval ends
      readyOut <= 1'b0;
      readyOe <= ~porDone_nxt;
    end
  end

  // Address and bit counters; a clear outranks a link edge in the same cycle
  always @* begin
    addr_nxt = addr_r;
    bit_nxt = bit_r;
    done_nxt = done_r;
    if (clearCnt) begin
      addr_nxt = {AW{1'b0}};
      bit_nxt = {BW{1'b0}};
      done_nxt = 1'b0;
    end else if (take_edge(readEn, linkRise, done_r)) begin
      if (lastBit) begin
        done_nxt = 1'b1;
      end else if (bit_r == LAST_BIT) begin
        bit_nxt = {BW{1'b0}};
        addr_nxt = addr_r + 1'b1;
      end else begin
        bit_nxt = bit_r + 1'b1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      addr_r <= {AW{1'b0}};
      bit_r <= {BW{1'b0}};
      done_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      bit_r <= bit_nxt;
      done_r <= done_nxt;
    end
  end

  // Data pin; the word read is the one the counters point at
  always @(posedge core_clk) begin
    if (rst) begin
      serialData <= 1'b0;
      serialDataOe <= 1'b0;
      standby <= 1'b0;
    end else begin
      serialData <= rdWord[bit_r];
      // Drop the driver as soon as the final edge is taken
      serialDataOe <= drive & ~(take_edge(readEn, linkRise, done_r) & lastBit);
      standby <= ~ceLow & ~progMode;
    end
  end

  // Chain-enable sequencing
  always @* begin
    chnState_nxt = chnState_r;
    chn_nxt = 1'b1;
    case (chnState_r)
      CHN_HIGH: begin
        if (take_edge(readEn, linkRise, done_r) && lastBit && !clearCnt) begin
          chnState_nxt = CHN_LOW;
          chn_nxt = 1'b0;
        end
      end
      CHN_LOW: begin
        chn_nxt = 1'b0;
        if (!oeActive) begin
          chnState_nxt = CHN_HIGH;
          chn_nxt = 1'b1;
        end else if (!ceLow) begin
          chnState_nxt = CHN_FOLLOW;
          chn_nxt = 1'b1;
        end
      end
      CHN_FOLLOW: begin
        chn_nxt = ~ceLow;
        if (!oeActive) begin
          chnState_nxt = CHN_HIGH;
          chn_nxt = 1'b1;
        end
      end
      default: begin
        // Unused code falls back to the released state
        chnState_nxt = CHN_HIGH;
      end
    endcase
  end

  // Registered so the cascade pin never glitches while the state moves
  always @(posedge core_clk) begin
    if (rst) begin
      chnState_r <= CHN_HIGH;
      chain_enable_out_n <= 1'b1;
    end else begin
      chnState_r <= chnState_nxt;
      chain_enable_out_n <= chn_nxt;
    end
  end

  // Programming path; the FIFO stalls outside programming mode
  scm_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .inValid(progValid),
    .inData(progData),
    .inReady(progReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(progMode)
  );

  // Bytes leave the buffer only while programming, never under a running readout
  assign wrTake = fifoValid & progMode;

  always @(posedge core_clk) begin
    if (wrTake) begin
      mem[wrAddr_r] <= fifoData;
    end
  end

  always @(posedge core_clk) begin
    if (rst || !progMode) begin
      wrAddr_r <= {AW{1'b0}};
    end else if (wrTake) begin
      wrAddr_r <= wrAddr_r + 1'b1;
    end
  end
endmodule // scm_readout

// ==== bench/scm_readout_chk.sv ====
// Port checker for scm_readout.
// Assumes the bind below reaches every scm_readout instance.
`timescale 1ns/1ps
module scm_readout_chk (
  input wire core_clk,
  input wire rst,
  input wire chipEnableN,
  input wire resetOe,
  input wire program_mode_select_n,
  input wire clearPolarityInv,
  input wire progValid,
  input wire progReady,
  input wire serialDataOe,
  input wire chain_enable_out_n,
  input wire readyOe,
  input wire standby
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Clear level depends on the polarity input pin clearPolarityInv
  wire clrLvl = resetOe == clearPolarityInv;
  AST_POR_END: assert property ($fell(rst) |-> ##[38:42] !readyOe) else $error("ready held");
  AST_POR_HOLD: assert property (!readyOe |=> !readyOe) else $error("ready again");
  AST_POR_QUIET: assert property (readyOe |-> !serialDataOe) else $error("early drive");
  AST_STBY: assert property ((chipEnableN && program_mode_select_n)[*4] |=> standby) else $error("no standby");
  AST_STBY_OFF: assert property (standby |-> !serialDataOe) else $error("standby drive");
  AST_CLR: assert property (clrLvl[*4] |=> !serialDataOe && chain_enable_out_n) else $error("clear");
  AST_PROG: assert property ((!program_mode_select_n)[*4] |=> !serialDataOe && !standby) else $error("prog");
  AST_LAST: assert property ($fell(chain_enable_out_n) |-> !serialDataOe) else $error("handoff");
  cover property ($fell(chain_enable_out_n));
  cover property ($rose(standby));
  cover property (progValid && progReady);
endmodule // scm_readout_chk
bind scm_readout scm_readout_chk i_chk (.core_clk(core_clk), .rst(rst), .chipEnableN(chipEnableN),
  .resetOe(resetOe), .program_mode_select_n(program_mode_select_n), .clearPolarityInv(clearPolarityInv),
  .progValid(progValid), .progReady(progReady), .serialDataOe(serialDataOe),
  .chain_enable_out_n(chain_enable_out_n), .readyOe(readyOe), .standby(standby));

// ==== bench/scm_master_model.sv ====
// Master-side model: makes the bit clock and samples the data pin.
// Assumes the bench calls read_bits and compares what is collected.
`timescale 1ns/1ps
module scm_master_model (
  output reg linkClk,
  input wire serialData,
  input wire serialDataOe
);
  reg lastBit = 1'b0;
  // Released pin shows a moving pattern, not the old bit
  wire pin = serialDataOe ? serialData : ~lastBit;
  logic got[$];
  initial linkClk = 1'b0;
  // Clock stands low between reads
  task automatic read_bits(input int n);
    #7;
    repeat (n) begin
      #100;
      got.push_back(pin);
      lastBit = pin;
      linkClk = 1'b1;
      #100;
      linkClk = 1'b0;
    end
  endtask
endmodule // scm_master_model

// ==== bench/tb.sv ====
// Bench for scm_readout: buffered programming, readout, cascade, polarity.
// Assumes the master model drives the bit clock.
`timescale 1ns/1ps
`include "scm_regs.vh"
module tb;
  localparam int NBITS = 256;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg chipEnableN = 1'b1;
  reg resetOe = 1'b0;
  reg program_mode_select_n = 1'b1;
  reg clearPolarityInv = 1'b0;
  reg progValid = 1'b0;
  reg [`SCM_WORD_W-1:0] progData = 8'h00;
  reg [7:0] lfsr = 8'h08;
  reg [7:0] mem[$];
  wire progReady, serialData, serialDataOe, chain_enable_out_n, readyOut, readyOe, standby, linkClk;
  int fails = 0;
  int checked = 0;
  int i, n, p;
  always #12.5 core_clk = ~core_clk;
  scm_readout #(.STREAM_BITS(NBITS)) i_dut (.core_clk(core_clk), .rst(rst), .linkClk(linkClk),
    .chipEnableN(chipEnableN), .resetOe(resetOe), .program_mode_select_n(program_mode_select_n),
    .clearPolarityInv(clearPolarityInv), .progValid(progValid), .progData(progData), .progReady(progReady),
    .serialData(serialData), .serialDataOe(serialDataOe), .chain_enable_out_n(chain_enable_out_n),
    .readyOut(readyOut), .readyOe(readyOe), .standby(standby));
  scm_master_model i_master (.linkClk(linkClk), .serialData(serialData), .serialDataOe(serialDataOe));
  function automatic [7:0] nxt(input [7:0] v);
    nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic a, input logic e, input string m);
    checked++;
    if (a !== e) begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic rd(input int k);
    i_master.got.delete();
    i_master.read_bits(k);
    for (i = 0; i < k; i++) chk(i_master.got[i], mem[i / 8][i % 8], "bit");
    cyc(1);
  endtask
  initial begin
    cyc(16);
    rst = 1'b0;
    cyc(2);
    chk(readyOe, 1'b1, "pon");
    cyc(43);
    chk(readyOe, 1'b0, "por");
    chk(readyOut, 1'b0, "rdy");
    chk(standby, 1'b1, "stby");
    // Fill the buffer outside programming, then drain
    for (i = 0; i < NBITS / 8; i++) begin
      lfsr = nxt(lfsr);
      mem.push_back(lfsr);
      progValid = 1'b1;
      progData = lfsr;
      for (n = 0; n < 99 && progReady !== 1'b1; n++) cyc(1);
      chk(n < 99, 1'b1, "stall");
      if (n == 99) tally_and_finish;
      cyc(1);
    end
    progValid = 1'b0;
    cyc(2);
    chk(progReady, 1'b0, "full");
    program_mode_select_n = 1'b0;
    cyc(50);
    chk(progReady, 1'b1, "drain");
    chk(standby, 1'b0, "prog");
    $display("test program done");
    program_mode_select_n = 1'b1;
    chipEnableN = 1'b0;
    cyc(4);
    chk(serialDataOe, 1'b0, "clr");
    resetOe = 1'b1;
    cyc(6);
    chk(serialDataOe, 1'b1, "drv");
    rd(NBITS);
    cyc(4);
    chk(chain_enable_out_n, 1'b0, "chain");
    chk(serialDataOe, 1'b0, "off");
    chipEnableN = 1'b1;
    cyc(4);
    chk(chain_enable_out_n, 1'b1, "follow");
    chk(serialDataOe, 1'b0, "stbyoff");
    chipEnableN = 1'b0;
    cyc(4);
    chk(chain_enable_out_n, 1'b0, "follow");
    chk(serialDataOe, 1'b0, "held");
    $display("test readout done");
    for (p = 0; p < 2; p++) begin
      clearPolarityInv = p[0];
      resetOe = p[0];
      cyc(4);
      chk(chain_enable_out_n, 1'b1, "clr");
      chk(serialDataOe, 1'b0, "clr");
      resetOe = ~p[0];
      cyc(6);
      rd(16);
    end
    $display("test polarity done");
    tally_and_finish;
  end
  initial begin
    #300000;
    fails++;
    tally_and_finish;
  end
endmodule // tb
